// ---- pkg/sar_ctrl_pkg.sv ----
// constants and types for the sampling converter control logic
package sar_ctrl_pkg;

    localparam int unsigned RES_BITS      = 12;
    localparam int unsigned SHORT_BITS    = 8;
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // emulation-mode acquisition delay before hold, in ns
    localparam int unsigned EMU_ACQ_NS    = 1600;
    localparam int unsigned EMU_ACQ_CYC   = (EMU_ACQ_NS * 1000) / CLK_PERIOD_PS;
    // time spent on each approximation step, in ns
    localparam int unsigned STEP_NS       = 500;
    localparam int unsigned STEP_CYC      = (STEP_NS * 1000) / CLK_PERIOD_PS;

    localparam logic [3:0]  LEN_FULL      = 4'hc;
    localparam logic [3:0]  LEN_SHORT     = 4'h8;
    localparam logic [3:0]  LSB_NIBBLE    = 4'h0;
    localparam logic [11:0] RESULT_RESET  = 12'h000;

    typedef enum logic [3:0]
    {
        ST_IDLE    = 4'b0001,
        ST_ACQ     = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_LATCH   = 4'b1000
    } conv_state_e;

endpackage

// ---- core/sar_adc_host_interface.sv ----
// control and host-interface logic of a 12-bit sampling successive-approximation converter
`timescale 1ns/1ps
// **************************************************************
// Overview of operation
// - start when last of three start inputs true
// - capture length select at start transition
// - short conversion reads low nibble as zero
// - same start delay whichever input completes
// - busy high only during acquisition, conversion and the latch cycle
// - data outputs high impedance while busy
// - start transitions do not restart while busy
// - new start edge while busy recaptures length
// - outputs enabled only read, idle, selected
// - word width high enables all twelve bits
// - high byte carries result bits eleven..four
// - low byte carries bits three..zero, zeros
// - byte groups never enabled together while word width low
// - stand-alone falling edge blanks, high reads
// - control mode holds and converts at once
// - emulation mode inserts acquisition delay first
// - emulation acquisition plus conversion bounded
// - sample-hold tracks again after conversion
// - mode pin low selects emulation mode
// **************************************************************
module sar_adc_host_interface
    import sar_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // host control pins
    input  wire logic                   chip_en,
    input  wire logic                   chip_sel_n,
    input  wire logic                   read_conv,
    input  wire logic                   byte_addr_length_sel,
    input  wire logic                   word_width_sel,
    input  wire logic                   mode_sel,
    // comparator from the capacitor array
    input  wire logic                   comp_out,
    // capacitor array drive
    output logic [sar_ctrl_pkg::RES_BITS-1:0] trial_code,
    output logic                        hold,
    // host data pins and status
    output logic [sar_ctrl_pkg::RES_BITS-1:0] data_out,
    output logic [sar_ctrl_pkg::RES_BITS-1:0] data_oe,
    output logic                        busy
);
    import sar_ctrl_pkg::*;

    // **************************************************************
    // input synchronisers
    // **************************************************************
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] next_sync1;
    logic       start_prev;
    logic       next_start_prev;

    always_comb
    begin
        next_sync1 = {comp_out, mode_sel, word_width_sel, byte_addr_length_sel, read_conv, chip_sel_n, chip_en};
    end

    always_ff @(posedge mclk)
    begin
        sync1 <= next_sync1;
        sync2 <= sync1;
    end

    logic ce_s, cs_n_s, rc_s, addr_len_s, ww_s, emu_mode, comp_s;
    assign ce_s       = sync2[0];
    assign cs_n_s     = sync2[1];
    assign rc_s       = sync2[2];
    assign addr_len_s = sync2[3];
    assign ww_s     = sync2[4];
    assign emu_mode = ~sync2[5];
    assign comp_s   = sync2[6];

    // all three start inputs seen through the same two register stages, so whichever
    // input completes the condition the start delay is identical
    logic start_cond;
    logic start_edge;
    assign start_cond = ce_s & ~cs_n_s & ~rc_s;
    assign start_edge = start_cond & ~start_prev;

    always_comb
    begin
        next_start_prev = start_cond;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            start_prev <= 1'b1;
        else
            start_prev <= next_start_prev;
    end

    // **************************************************************
    // conversion sequencer
    // **************************************************************
    conv_state_e state, next_state;
    logic [15:0] timer, next_timer;
    logic [3:0]  step, next_step;
    logic [3:0]  conv_len, next_conv_len;
    logic [11:0] sar, next_sar;
    logic [11:0] result, next_result;
    logic        next_busy, next_hold;

    always_comb
    begin
        next_state    = state;
        next_timer    = timer;
        next_step     = step;
        next_conv_len = conv_len;
        next_sar      = sar;
        next_result   = result;
        next_busy     = busy;
        next_hold     = hold;
        // a start edge while busy only recaptures the length
        if (start_edge)
            next_conv_len = addr_len_s ? LEN_SHORT : LEN_FULL;
        case (state)
            ST_IDLE:
            begin
                if (start_edge)
                begin
                    next_busy  = 1'b1;
                    next_timer = 16'h0000;
                    next_sar   = 12'h800;
                    next_step  = 4'h0;
                    if (emu_mode)
                        next_state = ST_ACQ;
                    else
                    begin
                        next_hold  = 1'b1;
                        next_state = ST_CONVERT;
                    end
                end
            end
            ST_ACQ:
            begin
                if (timer == 16'(EMU_ACQ_CYC - 1))
                begin
                    next_timer = 16'h0000;
                    next_hold  = 1'b1;
                    next_state = ST_CONVERT;
                end
                else
                    next_timer = timer + 16'h0001;
            end
            ST_CONVERT:
            begin
                if (timer == 16'(STEP_CYC - 1))
                begin
                    next_timer = 16'h0000;
                    // keep or drop the trial bit, then try the next one down
                    next_sar[4'd11 - step] = comp_s;
                    // a late recapture to the short length must still end the run
                    if (step + 4'h1 >= conv_len)
                    begin
                        next_state  = ST_LATCH;
                        next_hold   = 1'b0;
                        next_result = (conv_len == LEN_SHORT) ? {next_sar[11:4], LSB_NIBBLE} : next_sar;
                    end
                    else
                    begin
                        next_sar[4'd10 - step] = 1'b1;
                        next_step = step + 4'h1;
                    end
                end
                else
                    next_timer = timer + 16'h0001;
            end
            ST_LATCH:
            begin
                // result already stored, so busy drops one cycle after it
                next_busy   = 1'b0;
                next_state  = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state    <= ST_IDLE;
            timer    <= 16'h0000;
            step     <= 4'h0;
            conv_len <= LEN_FULL;
            sar      <= RESULT_RESET;
            result   <= RESULT_RESET;
            busy     <= 1'b0;
            hold     <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            timer    <= next_timer;
            step     <= next_step;
            conv_len <= next_conv_len;
            sar      <= next_sar;
            result   <= next_result;
            busy     <= next_busy;
            hold     <= next_hold;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            trial_code <= RESULT_RESET;
        else
            trial_code <= next_sar;
    end

    // **************************************************************
    // output data path and enables
    // **************************************************************
    logic [11:0] next_data_out, next_data_oe;
    logic        rd_ok;
    assign rd_ok = rc_s & ~busy & ce_s & ~cs_n_s;

    always_comb
    begin
        next_data_out = result;
        next_data_oe  = 12'h000;
        if (rd_ok)
        begin
            if (ww_s)
                next_data_oe = 12'hfff;
            else if (!addr_len_s)
                next_data_oe = 12'hff0;
            else
            begin
                // low nibble group carries result bits 3..0, middle group forced zero
                next_data_out = {result[11:8], 4'h0, result[3:0]};
                next_data_oe  = 12'h0ff;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            data_out <= RESULT_RESET;
            data_oe  <= 12'h000;
        end
        else
        begin
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
        end
    end

    // **************************************************************
    // assertions
    // **************************************************************
    a_busy_blanks: assert property (@(posedge mclk) disable iff (!rstn) busy |-> ##1 (data_oe == 12'h000))
        else $error("outputs enabled while busy");
    a_start_busy: assert property (@(posedge mclk) disable iff (!rstn)
        (state == ST_IDLE && start_edge) |=> busy)
        else $error("start edge did not raise busy");
    a_no_restart: assert property (@(posedge mclk) disable iff (!rstn)
        (state == ST_CONVERT && start_edge) |=> state != ST_IDLE)
        else $error("conversion restarted or cut short");
    a_ctrl_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (state == ST_IDLE && start_edge && !emu_mode) |=> hold)
        else $error("control mode did not hold at once");
    a_emu_delay: assert property (@(posedge mclk) disable iff (!rstn)
        (state == ST_IDLE && start_edge && emu_mode) |=> !hold [*8])
        else $error("emulation mode held too early");
    a_latch_first: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(busy) |-> result == $past(conv_len == LEN_SHORT ? {sar[11:4], LSB_NIBBLE} : sar))
        else $error("result not latched before busy fell");
    a_short_zero: assert property (@(posedge mclk) disable iff (!rstn)
        ($fell(busy) && conv_len == LEN_SHORT) |-> result[3:0] == 4'h0)
        else $error("short conversion low nibble not zero");
    a_groups_apart: assert property (@(posedge mclk) disable iff (!rstn)
        !(data_oe[3:0] != 4'h0 && data_oe[11:8] != 4'h0 && data_oe[7:4] != 4'hf))
        else $error("byte groups enabled together");
    a_read_gate: assert property (@(posedge mclk) disable iff (!rstn)
        (data_oe != 12'h000) |-> $past(rd_ok))
        else $error("outputs enabled without read condition");
    a_track_after: assert property (@(posedge mclk) disable iff (!rstn)
        (state == ST_LATCH) |-> !hold)
        else $error("sample-hold not tracking after conversion");

    c_full_conv: cover property (@(posedge mclk) disable iff (!rstn) $fell(busy) && conv_len == LEN_FULL);
    c_short_conv: cover property (@(posedge mclk) disable iff (!rstn) $fell(busy) && conv_len == LEN_SHORT);
    c_emu_conv: cover property (@(posedge mclk) disable iff (!rstn) state == ST_ACQ ##1 state == ST_CONVERT);
    c_low_byte: cover property (@(posedge mclk) disable iff (!rstn) data_oe == 12'h0ff);

endmodule

// ---- tb/sar_array_model.sv ----
// behavioural capacitor array and comparator facing the control logic
`timescale 1ns/1ps
module sar_array_model
(
    // clock and analog stimulus
    input  wire logic        mclk,
    input  wire logic [11:0] vin,
    // control logic side
    input  wire logic [11:0] trial_code,
    input  wire logic        hold,
    output logic             comp_out
);
    logic [11:0] held;

    // tracks the input while released, keeps the charge while held
    always_ff @(posedge mclk)
    begin
        if (!hold)
            held <= vin;
    end

    // keep the trial bit while the trial level does not exceed the sample
    assign comp_out = (trial_code <= held);
endmodule

// ---- tb/sar_adc_host_interface_tb_top.sv ----
// self-checking bench for the converter control logic
`timescale 1ns/1ps
module sar_adc_host_interface_tb_top;
    import sar_ctrl_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        chip_en = 1'b0;
    logic        chip_sel_n = 1'b1;
    logic        read_conv = 1'b1;
    logic        byte_addr_length_sel = 1'b0;
    logic        word_width_sel = 1'b1;
    logic        mode_sel = 1'b1;
    logic [11:0] vin = 12'h000;
    logic [11:0] trial_code;
    logic [11:0] data_out;
    logic [11:0] data_oe;
    logic        hold;
    logic        busy;
    logic        comp_out;
    logic [23:0] exp_q[$];
    logic [23:0] e;
    logic [11:0] last_oe = 12'h000;
    logic [31:0] seed = 32'h4a3c3eac;
    int          err_total = 0;
    int          checked = 0;
    int          n12;
    int          n8;
    int          ne;
    int          nr;

    always #2.5 mclk = ~mclk;

    sar_adc_host_interface DUT (.mclk(mclk), .rstn(rstn), .chip_en(chip_en), .chip_sel_n(chip_sel_n),
        .read_conv(read_conv), .byte_addr_length_sel(byte_addr_length_sel), .word_width_sel(word_width_sel),
        .mode_sel(mode_sel), .comp_out(comp_out), .trial_code(trial_code), .hold(hold),
        .data_out(data_out), .data_oe(data_oe), .busy(busy));

    sar_array_model array (.mclk(mclk), .vin(vin), .trial_code(trial_code), .hold(hold), .comp_out(comp_out));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // each newly presented output pattern is one read result
    always @(negedge mclk)
    begin
        if (data_oe !== last_oe && data_oe !== 12'h000)
        begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
            chk(data_oe, e[23:12], "output enables");
            chk(data_out & data_oe, e[11:0] & e[23:12], "read data");
        end
        last_oe <= data_oe;
    end

    // trig 0: chip enable rises, 1: chip select falls, 2: read/convert falls
    task automatic conv(input int trig, input logic lsel, input logic lsel_re, input logic md, output int n);
        vin = seed[11:0];
        seed = xs(seed);
        @(negedge mclk);
        mode_sel = md;
        byte_addr_length_sel = lsel;
        chip_en = (trig != 0);
        chip_sel_n = (trig == 1);
        read_conv = (trig == 2);
        repeat (40) @(negedge mclk);
        case (trig)
            0: chip_en = 1'b1;
            1: chip_sel_n = 1'b0;
            default: read_conv = 1'b0;
        endcase
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        chk(12'(busy), 12'h001, "busy after start");
        n = 0;
        while (busy === 1'b1 && n < 3000)
        begin
            chk(data_oe, 12'h000, "enables while busy");
            if (n == 5)
                byte_addr_length_sel = lsel_re;
            if (n == 10)
                read_conv = 1'b1;
            if (n == 20)
                read_conv = 1'b0;
            if (n == 300)
                chk(12'(hold), 12'(md), "hold state");
            @(negedge mclk);
            n++;
        end
        if (n >= 3000)
        begin
            err_total++;
            results();
        end
        chk(12'(hold), 12'h000, "tracking after end");
        repeat (10) @(negedge mclk);
        chk(12'(busy), 12'h000, "no restart");
    endtask

    task automatic rd(input logic ww, input logic lsel, input logic [23:0] ex);
        @(negedge mclk);
        exp_q.push_back(ex);
        word_width_sel = ww;
        byte_addr_length_sel = lsel;
        chip_en = 1'b1;
        chip_sel_n = 1'b0;
        read_conv = 1'b1;
        repeat (6) @(negedge mclk);
    endtask

    initial
    begin
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        chk(12'(busy), 12'h000, "busy after reset");
        // stand-alone: only read/convert moves; a high level shows the previous result first
        rd(1'b1, 1'b0, {12'hfff, RESULT_RESET});
        conv(2, 1'b0, 1'b0, 1'b1, n12);
        rd(1'b1, 1'b1, {12'hfff, vin});
        rd(1'b0, 1'b0, {12'hff0, vin[11:4], 4'h0});
        rd(1'b0, 1'b1, {12'h0ff, 8'h00, vin[3:0]});
        $display("stand-alone full conversion done");
        conv(1, 1'b1, 1'b1, 1'b1, n8);
        rd(1'b1, 1'b0, {12'hfff, vin[11:4], 4'h0});
        chk(12'(n12 - n8), 12'(4 * STEP_CYC), "short length");
        $display("short conversion done");
        conv(0, 1'b0, 1'b0, 1'b0, ne);
        rd(1'b1, 1'b0, {12'hfff, vin});
        chk(12'(ne - n12), 12'(EMU_ACQ_CYC), "acquisition delay");
        chk(12'(ne <= 1600), 12'h001, "throughput bound");
        $display("emulation conversion done");
        conv(2, 1'b0, 1'b1, 1'b1, nr);
        rd(1'b1, 1'b0, {12'hfff, vin[11:4], 4'h0});
        chk(12'(nr), 12'(n8), "recaptured length");
        $display("length recapture done");
        results();
    end
endmodule
